// ---- accel_time_readout_regs_test.sv ----
/*
  Self-checking bench for the readout block.
  Assumes the host model drives the register bus and the bench the samples.
*/
`timescale 1ns/10ps
`default_nettype none
module accel_time_readout_regs_test;
  import acctr_pkg::*;
  // ----------------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------------
  // A short tick keeps the carry into the middle time byte within reach.
  localparam int TICK = 4;
  localparam logic [49:0] ROWS [6] = '{{36'habc123456, 6'h12, 8'hc0},
    {36'habc123456, 6'h13, 8'hab}, {36'hfff5f1000, 6'h14, 8'h10},
    {36'hfff5f1000, 6'h15, 8'h5f}, {36'h00180080e, 6'h16, 8'he0},
    {36'h00180080e, 6'h17, 8'h80}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  acctr_sample_t samp = '0;
  logic samp_v = 1'b0;
  acctr_axil_req_t req;
  acctr_axil_rsp_t rsp;
  logic irq;
  logic drdy;
  logic [31:0] v1;
  logic [31:0] v2;
  logic [7:0] d8;
  logic [1:0] r;
  int n_errors = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  acctr_readout_top #(.TICK_CYCLES(TICK)) dut_u (.i_clk(clk), .i_resetn(resetn),
    .i_ce(ce), .i_sample(samp), .i_sample_valid(samp_v), .i_axil(req),
    .o_axil(rsp), .o_irq(irq), .o_drdy(drdy));
  acctr_host_model host_u (.i_clk(clk), .i_rsp(rsp), .o_req(req));
  task automatic chk_data(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    chk_data({33'h0, g}, {33'h0, e});
  endtask
  task automatic rdc(input logic [5:0] ix, input logic [7:0] e);
    host_u.rd({ix, 2'b00}, v1, r);
    chk_data({r, v1}, {ACCTR_RESP_OKAY, 24'h0, e});
  endtask
  task automatic wrc(input logic [5:0] ix, input logic [7:0] v);
    host_u.wr({ix, 2'b00}, {24'h0, v}, r);
    chk_data({32'h0, r}, {32'h0, ACCTR_RESP_OKAY});
    #1;
  endtask
  task automatic send(input acctr_sample_t s);
    @(posedge clk);
    samp <= s;
    samp_v <= 1'b1;
    @(posedge clk);
    samp_v <= 1'b0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdc(6'h1b, 8'h01);
    rdc(6'h1b, 8'h00);
    rdc(6'h17, 8'h00);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      send(ROWS[i][49:14]);
      chk_flag(drdy, 1'b1);
      rdc(ROWS[i][13:8], ROWS[i][7:0]);
      #1;
      chk_flag(drdy, 1'b0);
    end
    $display("test samples done");
    host_u.rd(8'h60, v2, r);
    repeat (40) @(posedge clk);
    host_u.rd(8'h60, v1, r);
    d8 = v1[7:0] - v2[7:0];
    chk_flag(d8 inside {8'h0a, 8'h0b}, 1'b1);
    host_u.rd(8'h60, v2, r);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    host_u.rd(8'h60, v1, r);
    d8 = v1[7:0] - v2[7:0];
    chk_flag(d8 inside {8'h00, 8'h01}, 1'b1);
    send(36'h123456789);
    wrc(6'h30, 8'h01);
    chk_flag(drdy, 1'b0);
    rdc(6'h1b, 8'h01);
    rdc(6'h13, 8'h00);
    repeat (1100) @(posedge clk);
    rdc(6'h19, 8'h01);
    rdc(6'h1a, 8'h00);
    $display("test time done");
    host_u.rd(8'h00, v1, r);
    chk_data({r, v1}, {ACCTR_RESP_DECERR, 32'h0});
    host_u.wr(8'h04, 32'h1, r);
    chk_data({32'h0, r}, {32'h0, ACCTR_RESP_DECERR});
    wrc(6'h12, 8'hff);
    rdc(6'h12, 8'h00);
    $display("test refusals done");
    wrc(6'h32, 8'h01);
    wrc(6'h31, 8'h07);
    chk_flag(irq, 1'b0);
    send('0);
    chk_flag(irq, 1'b1);
    wrc(6'h31, 8'h01);
    chk_flag(irq, 1'b0);
    wrc(6'h32, 8'h00);
    send('0);
    chk_flag(irq, 1'b0);
    wrc(6'h32, 8'h01);
    chk_flag(irq, 1'b1);
    rdc(6'h32, 8'h01);
    $display("test interrupt done");
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    chk_flag(drdy, 1'b0);
    chk_flag(irq, 1'b0);
    rdc(6'h1b, 8'h01);
    $display("test second reset done");
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- acctr_host_model.sv ----
/*
  Host processor model: an AXI4-Lite master with one read and one write task.
  Assumes the bench calls one task at a time on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module acctr_host_model (
  input wire logic i_clk,
  input wire acctr_pkg::acctr_axil_rsp_t i_rsp,
  output var acctr_pkg::acctr_axil_req_t o_req
);
  import acctr_pkg::*;
  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // Released payloads are inverted so a stale value is never read as fresh.
  initial o_req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    o_req.awvalid <= 1'b1;
    o_req.awaddr <= a;
    o_req.wvalid <= 1'b1;
    o_req.wdata <= d;
    o_req.wstrb <= 4'hf;
    o_req.bready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_req.awvalid && i_rsp.awready)
      begin
        o_req.awvalid <= 1'b0;
        o_req.awaddr <= ~a;
      end
      if (o_req.wvalid && i_rsp.wready)
      begin
        o_req.wvalid <= 1'b0;
        o_req.wdata <= ~d;
      end
    end
    while (!i_rsp.bvalid);
    r = i_rsp.bresp;
    o_req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    o_req.arvalid <= 1'b1;
    o_req.araddr <= a;
    o_req.rready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_req.arvalid && i_rsp.arready)
      begin
        o_req.arvalid <= 1'b0;
        o_req.araddr <= ~a;
      end
    end
    while (!i_rsp.rvalid);
    d = i_rsp.rdata;
    r = i_rsp.rresp;
    o_req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- acctr_irq_bank.sv ----
/*
  Sticky interrupt status with write-one-to-clear, a mask and one level output.
  Assumes event pulses and write strobes on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module acctr_irq_bank (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [2:0] i_events,
  input wire logic i_wr_status,
  input wire logic i_wr_mask,
  input wire logic [2:0] i_wdata,
  output logic [2:0] o_status,
  output logic [2:0] o_mask,
  output logic o_irq
);
  import acctr_pkg::*;

  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
  } acctr_irq_state_t;

  acctr_irq_state_t q;
  acctr_irq_state_t d;

  always_comb
  begin
    d = q;
    // A new event in the clearing cycle survives the clear.
    d.status = (q.status & ~(i_wr_status ? i_wdata : 3'h0)) | i_events;
    if (i_wr_mask)
    begin
      d.mask = i_wdata;
    end
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  assign o_status = q.status;
  assign o_mask = q.mask;
  assign o_irq = q.irq;

endmodule

`default_nettype wire

// ---- acctr_pkg.sv ----
/*
  Shared constants, carrier types and decode functions for the acceleration
  and sensor time readout block.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register master.
*/
`default_nettype none

package acctr_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ACCTR_ADDR_W = 8;
  localparam int ACCTR_DATA_W = 32;
  localparam int ACCTR_IDX_W = 6;
  localparam int ACCTR_SAMPLE_W = 12;
  localparam int ACCTR_TIME_W = 24;
  localparam int ACCTR_PRESCALE_W = 14;
  localparam int ACCTR_IRQ_W = 3;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] ACCTR_IDX_ACCEL_X_LOW = 6'h12;
  localparam logic [5:0] ACCTR_IDX_ACCEL_X_HIGH = 6'h13;
  localparam logic [5:0] ACCTR_IDX_ACCEL_Y_LOW = 6'h14;
  localparam logic [5:0] ACCTR_IDX_ACCEL_Y_HIGH = 6'h15;
  localparam logic [5:0] ACCTR_IDX_ACCEL_Z_LOW = 6'h16;
  localparam logic [5:0] ACCTR_IDX_ACCEL_Z_HIGH = 6'h17;
  localparam logic [5:0] ACCTR_IDX_TIME_BYTE0 = 6'h18;
  localparam logic [5:0] ACCTR_IDX_TIME_BYTE1 = 6'h19;
  localparam logic [5:0] ACCTR_IDX_TIME_BYTE2 = 6'h1a;
  localparam logic [5:0] ACCTR_IDX_RESET_EVENT = 6'h1b;
  localparam logic [5:0] ACCTR_IDX_CTRL = 6'h30;
  localparam logic [5:0] ACCTR_IDX_IRQ_STATUS = 6'h31;
  localparam logic [5:0] ACCTR_IDX_IRQ_MASK = 6'h32;
  localparam logic [5:0] ACCTR_IDX_SENSOR_STATUS = 6'h33;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int ACCTR_POR_BIT = 0;
  localparam int ACCTR_SOFT_RESET_BIT = 0;
  localparam int ACCTR_DRDY_BIT = 0;
  localparam int ACCTR_EV_DRDY = 0;
  localparam int ACCTR_EV_POR = 1;
  localparam int ACCTR_EV_WRAP = 2;
  localparam logic [7:0] ACCTR_EVENT_RST = 8'h01;
  localparam logic [7:0] ACCTR_DATA_RST = 8'h00;
  localparam logic [2:0] ACCTR_IRQ_RST = 3'h0;
  localparam logic [1:0] ACCTR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACCTR_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  // One time count is 39.0625 us; bit 8 then weighs 10 ms and bit 16 2.56 s.
  localparam real ACCTR_TICK_US = 39.0625;
  localparam real ACCTR_CLK_MHZ = 250.0;
  localparam int ACCTR_TICK_CYCLES = int'($floor(ACCTR_TICK_US * ACCTR_CLK_MHZ));

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } acctr_sample_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } acctr_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acctr_axil_rsp_t;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] acctr_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic acctr_is_mapped(input logic [5:0] idx);
    return ((idx >= ACCTR_IDX_ACCEL_X_LOW) && (idx <= ACCTR_IDX_RESET_EVENT)) ||
           ((idx >= ACCTR_IDX_CTRL) && (idx <= ACCTR_IDX_SENSOR_STATUS));
  endfunction

  function automatic logic [7:0] acctr_low_byte(input logic [11:0] s);
    return {s[3:0], 4'h0};
  endfunction

  function automatic logic [7:0] acctr_high_byte(input logic [11:0] s);
    return s[11:4];
  endfunction

endpackage

`default_nettype wire

// ---- acctr_readout_sva.sv ----
/*
  Checker for the readout block, bound to its top module.
  Assumes one AXI4-Lite read and one write in flight at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module acctr_readout_sva #(
  parameter int TICK_CYCLES = acctr_pkg::ACCTR_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire acctr_pkg::acctr_sample_t i_sample,
  input wire logic i_sample_valid,
  input wire acctr_pkg::acctr_axil_req_t i_axil,
  input wire acctr_pkg::acctr_axil_rsp_t o_axil,
  input wire logic o_irq,
  input wire logic o_drdy
);
  import acctr_pkg::*;
  // ----------------------------------------------------------------------
  // Shadow of what a read should return
  // ----------------------------------------------------------------------
  // Any write may be a soft reset, so it drops the shadow until the next sample.
  wire logic ar_t = i_ce && i_axil.arvalid && o_axil.arready;
  wire logic aw_t = i_ce && i_axil.awvalid && o_axil.awready;
  wire logic w_t = i_ce && i_axil.wvalid && o_axil.wready;
  wire logic sv_t = i_ce && i_sample_valid;
  wire logic [5:0] ar_ix = i_axil.araddr[7:2];
  acctr_sample_t samp_q;
  logic ok_q;
  logic clean_q;
  logic evrd_q;
  logic aok_q;
  logic [1:0] aev_q;
  logic [5:0] ix_q;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      samp_q <= '0;
      ok_q <= 1'b1;
      clean_q <= 1'b1;
      evrd_q <= 1'b0;
      aok_q <= 1'b0;
      aev_q <= 2'h0;
      ix_q <= 6'h00;
    end
    else
    begin
      if (sv_t)
      begin
        samp_q <= i_sample;
        ok_q <= 1'b1;
      end
      // The later of the two write channels completes the write, so both count.
      if (aw_t || w_t)
      begin
        ok_q <= 1'b0;
        clean_q <= 1'b0;
        evrd_q <= 1'b0;
      end
      if (ar_t)
      begin
        ix_q <= ar_ix;
        aok_q <= ok_q && !sv_t;
        aev_q <= {clean_q, evrd_q};
        if (ar_ix == ACCTR_IDX_RESET_EVENT)
          evrd_q <= 1'b1;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_x_low:
    assert property ($rose(o_axil.rvalid) && ix_q == ACCTR_IDX_ACCEL_X_LOW && aok_q
      |-> o_axil.rdata == {24'h0, samp_q.x[3:0], 4'h0}) else $error("x low wrong");
  chk_y_high:
    assert property ($rose(o_axil.rvalid) && ix_q == ACCTR_IDX_ACCEL_Y_HIGH && aok_q
      |-> o_axil.rdata == {24'h0, samp_q.y[11:4]}) else $error("y high wrong");
  chk_z_low:
    assert property ($rose(o_axil.rvalid) && ix_q == ACCTR_IDX_ACCEL_Z_LOW && aok_q
      |-> o_axil.rdata == {24'h0, samp_q.z[3:0], 4'h0}) else $error("z low wrong");
  chk_byte_wide:
    assert property (o_axil.rvalid && o_axil.rresp == ACCTR_RESP_OKAY
      |-> o_axil.rdata[31:8] == 24'h0) else $error("upper data bits set");
  chk_flag_set:
    assert property ($rose(o_axil.rvalid) && ix_q == ACCTR_IDX_RESET_EVENT && aev_q == 2'b10
      |-> o_axil.rdata == 32'h1) else $error("reset flag not set");
  chk_flag_clear:
    assert property ($rose(o_axil.rvalid) && ix_q == ACCTR_IDX_RESET_EVENT && aev_q[0]
      |-> o_axil.rdata == 32'h0) else $error("reset flag not cleared");
  chk_drdy_set:
    assert property (sv_t |=> o_drdy) else $error("data ready not set");
  chk_drdy_clear:
    assert property (ar_t && ar_ix >= ACCTR_IDX_ACCEL_X_LOW && ar_ix <= ACCTR_IDX_ACCEL_Z_HIGH
      && !sv_t |=> !o_drdy) else $error("data ready not cleared");
endmodule
bind acctr_readout_top acctr_readout_sva #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_ce(i_ce),
  .i_sample(i_sample),
  .i_sample_valid(i_sample_valid),
  .i_axil(i_axil),
  .o_axil(o_axil),
  .o_irq(o_irq),
  .o_drdy(o_drdy)
);
`default_nettype wire

// ---- acctr_readout_top.sv ----
/*
  Register view of a triaxial acceleration sample, a sensor time counter and a
  reset-detected flag, reached over an AXI4-Lite slave.
  Assumes samples arrive from front-end logic on the same clock as a valid
  pulse, and that the AXI master keeps one write and one read in flight.
*/
`timescale 1ns/10ps
`default_nettype none

module acctr_readout_top #(
  parameter int TICK_CYCLES = acctr_pkg::ACCTR_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire acctr_pkg::acctr_sample_t i_sample,
  input wire logic i_sample_valid,
  input wire acctr_pkg::acctr_axil_req_t i_axil,
  output var acctr_pkg::acctr_axil_rsp_t o_axil,
  output logic o_irq,
  output logic o_drdy
);
  import acctr_pkg::*;

  // ----------------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    acctr_sample_t sample;
    logic drdy;
    logic por;
  } acctr_top_state_t;

  acctr_top_state_t q;
  acctr_top_state_t d;

  // ----------------------------------------------------------------------
  // Strobes and decoded values
  // ----------------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic soft_rst;
  logic irq_wr_status;
  logic irq_wr_mask;
  logic rd_accel;
  logic rd_event;
  logic [7:0] rd_byte;
  logic [23:0] time_count;
  logic time_wrap;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  // Readies drop with the clock enable so no address or write data is accepted while frozen.
  // Each response stands in its register until the master's ready is seen high.
  always_comb
  begin
    o_axil = '0;
    o_axil.awready = i_ce & ~q.aw_got & ~q.bvalid;
    o_axil.wready = i_ce & ~q.w_got & ~q.bvalid;
    o_axil.arready = i_ce & ~q.rvalid;
    o_axil.bvalid = q.bvalid;
    o_axil.bresp = q.bresp;
    o_axil.rvalid = q.rvalid;
    o_axil.rdata = q.rdata;
    o_axil.rresp = q.rresp;
  end

  assign aw_take = i_axil.awvalid & o_axil.awready;
  assign w_take = i_axil.wvalid & o_axil.wready;
  assign ar_take = i_axil.arvalid & o_axil.arready;

  // Address and data may arrive in either order; the write acts once both are in.
  // The captured halves are released as the response is set up, so a new pair
  // is only accepted once the master has taken bvalid.
  assign wr_addr = q.aw_got ? q.aw_addr : i_axil.awaddr;
  assign wr_data = q.w_got ? q.w_data : i_axil.wdata;
  assign wr_strb = q.w_got ? q.w_strb : i_axil.wstrb;
  assign wr_fire = i_ce & ~q.bvalid & (q.aw_got | aw_take) & (q.w_got | w_take);
  assign wr_idx = acctr_index(wr_addr);
  assign rd_idx = acctr_index(i_axil.araddr);

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    soft_rst = 1'b0;
    irq_wr_status = 1'b0;
    irq_wr_mask = 1'b0;
    // Every field lives in byte lane 0; a write with that lane off changes nothing.
    if (wr_fire && wr_strb[0] && (wr_idx == ACCTR_IDX_CTRL))
    begin
      soft_rst = wr_data[ACCTR_SOFT_RESET_BIT];
    end
    else if (wr_fire && wr_strb[0] && (wr_idx == ACCTR_IDX_IRQ_STATUS))
    begin
      irq_wr_status = 1'b1;
    end
    else if (wr_fire && wr_strb[0] && (wr_idx == ACCTR_IDX_IRQ_MASK))
    begin
      irq_wr_mask = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    // Unmapped and write-only indices read zero; only for unmapped ones does the
    // DECERR response tell the master that nothing answers, write-only ones answer OKAY.
    rd_byte = ACCTR_DATA_RST;
    if (rd_idx == ACCTR_IDX_ACCEL_X_LOW)
    begin
      rd_byte = acctr_low_byte(q.sample.x);
    end
    else if (rd_idx == ACCTR_IDX_ACCEL_X_HIGH)
    begin
      rd_byte = acctr_high_byte(q.sample.x);
    end
    else if (rd_idx == ACCTR_IDX_ACCEL_Y_LOW)
    begin
      rd_byte = acctr_low_byte(q.sample.y);
    end
    else if (rd_idx == ACCTR_IDX_ACCEL_Y_HIGH)
    begin
      rd_byte = acctr_high_byte(q.sample.y);
    end
    else if (rd_idx == ACCTR_IDX_ACCEL_Z_LOW)
    begin
      rd_byte = acctr_low_byte(q.sample.z);
    end
    else if (rd_idx == ACCTR_IDX_ACCEL_Z_HIGH)
    begin
      rd_byte = acctr_high_byte(q.sample.z);
    end
    // The time bytes are not frozen together, so reading all three can straddle
    // a carry; software wanting a coherent value reads the bytes twice.
    // time bytes
    else if (rd_idx == ACCTR_IDX_TIME_BYTE0)
    begin
      rd_byte = time_count[7:0];
    end
    else if (rd_idx == ACCTR_IDX_TIME_BYTE1)
    begin
      rd_byte = time_count[15:8];
    end
    else if (rd_idx == ACCTR_IDX_TIME_BYTE2)
    begin
      rd_byte = time_count[23:16];
    end
    else if (rd_idx == ACCTR_IDX_RESET_EVENT)
    begin
      rd_byte[ACCTR_POR_BIT] = q.por;
    end
    else if (rd_idx == ACCTR_IDX_IRQ_STATUS)
    begin
      rd_byte = {5'h0, irq_status};
    end
    else if (rd_idx == ACCTR_IDX_IRQ_MASK)
    begin
      rd_byte = {5'h0, irq_mask};
    end
    else if (rd_idx == ACCTR_IDX_SENSOR_STATUS)
    begin
      rd_byte[ACCTR_DRDY_BIT] = q.drdy;
    end
  end

  // ----------------------------------------------------------------------
  // Read side effects
  // ----------------------------------------------------------------------
  // Side effects act on the edge that accepts the read address, not on rvalid.
  // data register read
  assign rd_accel = ar_take && (rd_idx >= ACCTR_IDX_ACCEL_X_LOW) &&
                    (rd_idx <= ACCTR_IDX_ACCEL_Z_HIGH);
  assign rd_event = ar_take && (rd_idx == ACCTR_IDX_RESET_EVENT);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (aw_take)
    begin
      d.aw_got = 1'b1;
      d.aw_addr = i_axil.awaddr;
    end
    if (w_take)
    begin
      d.w_got = 1'b1;
      d.w_data = i_axil.wdata;
      d.w_strb = i_axil.wstrb;
    end
    if (wr_fire)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      // Read-only targets answer OKAY and simply drop the data.
      d.bresp = acctr_is_mapped(wr_idx) ? ACCTR_RESP_OKAY : ACCTR_RESP_DECERR;
    end
    else if (q.bvalid && i_axil.bready)
    begin
      d.bvalid = 1'b0;
    end
    if (ar_take)
    begin
      d.rvalid = 1'b1;
      d.rdata = {24'h0, rd_byte};
      d.rresp = acctr_is_mapped(rd_idx) ? ACCTR_RESP_OKAY : ACCTR_RESP_DECERR;
    end
    else if (q.rvalid && i_axil.rready)
    begin
      d.rvalid = 1'b0;
    end
    // A soft reset drops the held sample; a sample landing with it is kept.
    if (soft_rst)
    begin
      d.sample = '0;
    end
    if (i_sample_valid)
    begin
      d.sample = i_sample;
    end
    // A sample landing with a data read keeps the flag set, so a fresh sample is
    // never hidden behind a read of the one before it.
    // clear on data read
    if (rd_accel || soft_rst)
    begin
      d.drdy = 1'b0;
    end
    if (i_sample_valid)
    begin
      d.drdy = 1'b1;
    end
    if (rd_event)
    begin
      d.por = 1'b0;
    end
    // Ordered after the read clear so a soft reset in the same cycle wins.
    // set by soft reset
    if (soft_rst)
    begin
      d.por = 1'b1;
    end
  end

  // Reset leaves the bus idle and the sample zero, with the flag raised.
  // flag set at power-up
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
      q.por <= ACCTR_EVENT_RST[ACCTR_POR_BIT];
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Sensor time and interrupts
  // ----------------------------------------------------------------------
  // counter instance
  acctr_time_base #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_time_base (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_clear(soft_rst),
    .o_count(time_count),
    .o_wrap(time_wrap)
  );

  // Interrupt status and mask survive a soft reset, so software still sees the
  // soft-reset event once it has happened.
  always_comb
  begin
    irq_events = '0;
    irq_events[ACCTR_EV_DRDY] = i_sample_valid;
    irq_events[ACCTR_EV_POR] = soft_rst;
    irq_events[ACCTR_EV_WRAP] = time_wrap;
  end

  acctr_irq_bank u_irq_bank (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_events(irq_events),
    .i_wr_status(irq_wr_status),
    .i_wr_mask(irq_wr_mask),
    .i_wdata(wr_data[2:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_drdy = q.drdy;

endmodule

`default_nettype wire

// ---- acctr_time_base.sv ----
/*
  Free-running sensor time counter with its tick prescaler.
  Assumes the system clock and a synchronous clear pulse from the owner.
*/
`timescale 1ns/10ps
`default_nettype none

module acctr_time_base #(
  parameter int TICK_CYCLES = acctr_pkg::ACCTR_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_clear,
  output logic [23:0] o_count,
  output logic o_wrap
);
  import acctr_pkg::*;

  typedef struct packed {
    logic [13:0] pre;
    logic [23:0] count;
    logic wrap;
  } acctr_tb_state_t;

  localparam logic [13:0] TICK_LAST = ACCTR_PRESCALE_W'(TICK_CYCLES - 1);

  acctr_tb_state_t q;
  acctr_tb_state_t d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.wrap = 1'b0;
    if (i_clear)
    begin
      d.pre = '0;
      d.count = '0;
    end
    else if (q.pre == TICK_LAST)
    begin
      d.pre = '0;
      d.count = q.count + 24'h1;
      d.wrap = (q.count == 24'hffffff);
    end
    else
    begin
      d.pre = q.pre + 14'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  assign o_count = q.count;
  assign o_wrap = q.wrap;

endmodule

`default_nettype wire
